// *** spcfg_defines.svh ***
// register offsets, field positions, reset values and timing counts for the serial config block
`ifndef SPCFG_DEFINES_SVH
`define SPCFG_DEFINES_SVH

// word-aligned byte offsets on the register bus
`define SPCFG_OFF_CTRL1   4'h0
`define SPCFG_OFF_CTRL2   4'h4
`define SPCFG_OFF_BAUD    4'h8
`define SPCFG_OFF_STATUS  4'hc

// control one field positions
`define SPCFG_C1_SELECT_OUTPUT_ENABLE     1
`define SPCFG_C1_MASTER_SELECT     4
`define SPCFG_C1_UEN      6
// control two field positions
`define SPCFG_C2_MIE      7
`define SPCFG_C2_WIDTH    6
`define SPCFG_C2_FEN      4
`define SPCFG_C2_BOE      3
`define SPCFG_C2_WSTOP    1
`define SPCFG_C2_SPC      0
`define SPCFG_C2_MASK     8'hdb
// status field positions
`define SPCFG_ST_MATCH    6
`define SPCFG_ST_FAULT    4
`define SPCFG_ST_IDLE     0

// reset values
`define SPCFG_C1_RST      8'h00
`define SPCFG_C2_RST      8'h00
`define SPCFG_BR_RST      8'h00

// synchroniser depth on pin inputs
`define SPCFG_SYNC_DEPTH  3

`endif

// *** spcfg_pkg.sv ***
// types shared by the serial config block
package spcfg_pkg;

    // pin function of the select pin
    typedef enum logic [1:0] {
        SPCFG_SS_GPIO,
        SPCFG_SS_FAULT_IN,
        SPCFG_SS_AUTO_OUT,
        SPCFG_SS_SLAVE_IN
    } spcfg_ss_fn_t;

    // baud divider state
    typedef enum logic [1:0] {
        SPCFG_BD_IDLE,
        SPCFG_BD_RUN
    } spcfg_bd_st_t;

endpackage : spcfg_pkg

// *** spcfg_baud_if.sv ***
// carrier between the register core and the baud generator
`timescale 1ns/1ns
`default_nettype none
interface spcfg_baud_if;
    logic [2:0] prescale_code;     // prescale divisor minus one
    logic [2:0] rate_divider_code; // power-of-two rate code
    logic       run;               // generator running
    logic       sck;               // generated serial clock level
    logic       tick;              // one-cycle pulse on every sck toggle while running
    modport gen  (input prescale_code, input rate_divider_code, input run, output sck, output tick);
    modport core (output prescale_code, output rate_divider_code, output run, input sck, input tick);
endinterface : spcfg_baud_if
`default_nettype wire

// *** spcfg_baud_gen.sv ***
// master serial clock generator: prescaler then power-of-two divider
`timescale 1ns/1ns
`default_nettype none
`include "spcfg_defines.svh"
module spcfg_baud_gen (
    input  wire logic     clk,  // bus clock
    input  wire logic     rst_n, // synchronous reset, active low
    spcfg_baud_if.gen     bif   // divider settings and clock out
);
    import spcfg_pkg::*;

    typedef struct packed {
        logic [2:0] pre_cnt;
        logic [7:0] rate_cnt;
        logic       sck;
        logic       tick;
    } spcfg_bg_t;

    spcfg_bg_t s_q;
    spcfg_bg_t s_d;
    logic [7:0] half_lim;

    // half the rate divisor counts prescaler outputs between sck edges
    assign half_lim = 8'(8'h01 << bif.rate_divider_code) - 8'h01;

    // prescale counter wraps at code+1, rate counter at half divisor
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (!bif.run) begin
            s_d.pre_cnt  = 3'h0;
            s_d.rate_cnt = 8'h00;
            s_d.sck      = 1'b0;
        end else if (s_q.pre_cnt >= bif.prescale_code) begin
            s_d.pre_cnt = 3'h0;
            if (s_q.rate_cnt >= half_lim) begin
                s_d.rate_cnt = 8'h00;
                s_d.sck      = ~s_q.sck;
                s_d.tick     = 1'b1;
            end else begin
                s_d.rate_cnt = s_q.rate_cnt + 8'h01;
            end
        end else begin
            s_d.pre_cnt = s_q.pre_cnt + 3'h1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bif.sck  = s_q.sck;
    assign bif.tick = s_q.tick;
endmodule : spcfg_baud_gen
`default_nettype wire

// *** spcfg_sync.sv ***
// three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ns
`default_nettype none
`include "spcfg_defines.svh"
module spcfg_sync (
    input  wire logic clk,   // bus clock
    input  wire logic rst_n, // synchronous reset, active low
    input  wire logic d,     // asynchronous pin level
    input  wire logic init,  // value held after reset
    output var  logic q      // filtered level
);
    typedef struct packed {
        logic [`SPCFG_SYNC_DEPTH-1:0] sr;
        logic                         q;
    } spcfg_sy_t;

    spcfg_sy_t s_q;
    spcfg_sy_t s_d;

    // shift in; output follows only when stages two and three agree
    always_comb begin
        s_d    = s_q;
        s_d.sr = {s_q.sr[1:0], d};
        if (s_q.sr[1] == s_q.sr[2]) begin
            s_d.q = s_q.sr[2];
        end
    end

    // state register; reset loads the pin's idle level everywhere
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= {(`SPCFG_SYNC_DEPTH + 1){init}};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.q;
endmodule : spcfg_sync
`default_nettype wire

// *** spcfg_top.sv ***
// serial peripheral pin configuration, width select and baud generation with register slave
// What this block does
// - master with fault off: select pin released to general I/O regardless of output enable
// - master with fault on: select pin is fault input or automatic select output
// - slave: select pin always the select input; fault and output enable ignored
// - match flag with match interrupt enable raises the interrupt; otherwise none
// - width bit picks 8 or 16 bits for shifter, match and buffers
// - master width change aborts transfer, goes idle and clears all status
// - single wire: output enable 0 makes shared pin input, 1 drives it
// - single wire: master uses master-out pin, slave uses slave-out pin
// - pin control 0 uses separate pins, 1 uses single bidirectional wire
// - wait-stop bit 1 halts unit clocks in wait mode, 0 keeps them running
// - prescaler divides bus clock by code plus one, one to eight
// - rate divider divides by two to the code plus one, two to 256
// - baud register readable and writable at all times
// - unit disabled: all four serial pins return to general port I/O
`timescale 1ns/1ns
`default_nettype none
`include "spcfg_defines.svh"
module spcfg_top (
    input  wire logic        CORE_CLK,        // bus clock, 50 MHz
    input  wire logic        RST_N,           // synchronous reset, active low
    input  wire logic [3:0]  AVS_ADDRESS,     // byte address
    input  wire logic        AVS_READ,        // read strobe
    input  wire logic        AVS_WRITE,       // write strobe
    input  wire logic [31:0] AVS_WRITEDATA,   // write data
    input  wire logic [3:0]  AVS_BYTEENABLE,  // byte lanes
    output var  logic [31:0] AVS_READDATA,    // read data
    output var  logic        AVS_WAITREQUEST, // stall until answer
    output var  logic        IRQ,             // level interrupt
    input  wire logic        WAIT_MODE,       // processor in wait mode
    input  wire logic        RX_MATCH_EVENT,  // receive buffer matched match value
    output var  logic        WIDTH_16,        // 1: 16-bit shifter, match, buffers
    output var  logic        ABORT,           // pulse: abort transfer, force idle
    output var  logic        UNIT_CLK_RUN,    // unit clocks allowed to run
    output var  logic        SPI_ACTIVE,      // 0: all four pins are port I/O
    input  wire logic        SCK_I,           // serial clock pin in
    output var  logic        SCK_O,           // serial clock pin out
    output var  logic        SCK_OE_N,        // serial clock drive, low drives
    input  wire logic        MOSI_I,          // master-out pin in
    input  wire logic        MOSI_TX,         // data to shift out on master-out
    output var  logic        MOSI_O,          // master-out pin out
    output var  logic        MOSI_OE_N,       // master-out drive, low drives
    output var  logic        MOSI_GPIO,       // master-out pin returned to port
    input  wire logic        MISO_I,          // slave-out pin in
    input  wire logic        MISO_TX,         // data to shift out on slave-out
    output var  logic        MISO_O,          // slave-out pin out
    output var  logic        MISO_OE_N,       // slave-out drive, low drives
    output var  logic        MISO_GPIO,       // slave-out pin returned to port
    output var  logic        RX_DATA,         // received serial bit, synchronised
    input  wire logic        SS_I,            // select pin in
    input  wire logic        SS_ASSERT,       // transfer active, for automatic select
    output var  logic        SS_O,            // select pin out
    output var  logic        SS_OE_N,         // select drive, low drives
    output var  logic        SS_GPIO,         // select pin returned to port
    output var  logic        SLAVE_SELECTED   // slave selected by external master
);
    import spcfg_pkg::*;

    typedef struct packed {
        logic [7:0]   ctrl1;
        logic [7:0]   ctrl2;
        logic [7:0]   baud;
        logic         match_flag;
        logic         fault_flag;
        logic         rd_seen_match;
        logic         rd_seen_fault;
        logic         ack;
        logic [31:0]  rdata;
        logic         irq;
        logic         abort;
        logic         clk_run;
        logic         active;
        spcfg_ss_fn_t ss_fn;
        logic         sck_o;
        logic         sck_oe_n;
        logic         mosi_o;
        logic         mosi_oe_n;
        logic         mosi_gpio;
        logic         miso_o;
        logic         miso_oe_n;
        logic         miso_gpio;
        logic         rx;
        logic         ss_o;
        logic         ss_oe_n;
        logic         ss_gpio;
        logic         selected;
    } spcfg_st_t;

    spcfg_st_t s_q;
    spcfg_st_t s_d;
    spcfg_baud_if bif ();
    logic ss_s;
    logic sck_s;
    logic mosi_s;
    logic miso_s;

    // pin inputs through synchronisers
    spcfg_sync u_ss   (.clk(CORE_CLK), .rst_n(RST_N), .d(SS_I),   .init(1'b1), .q(ss_s));
    spcfg_sync u_sck  (.clk(CORE_CLK), .rst_n(RST_N), .d(SCK_I),  .init(1'b1), .q(sck_s));
    spcfg_sync u_mosi (.clk(CORE_CLK), .rst_n(RST_N), .d(MOSI_I), .init(1'b1), .q(mosi_s));
    spcfg_sync u_miso (.clk(CORE_CLK), .rst_n(RST_N), .d(MISO_I), .init(1'b1), .q(miso_s));

    // baud generator runs only in enabled master mode with clocks live
    spcfg_baud_gen u_baud (.clk(CORE_CLK), .rst_n(RST_N), .bif(bif.gen));
    assign bif.prescale_code     = s_q.baud[6:4];
    assign bif.rate_divider_code = s_q.baud[2:0];
    assign bif.run               = s_q.active & s_q.clk_run & s_q.ctrl1[`SPCFG_C1_MASTER_SELECT];

    // register access, flags, pin functions
    always_comb begin
        logic       master;
        logic       fen;
        logic       select_output_enable;
        logic       spc;
        logic       boe;
        logic       wr;
        logic       rd;
        logic [7:0] wbyte;
        logic       match_clr;
        logic       fault_clr;
        logic       fault_ev;
        master    = s_q.ctrl1[`SPCFG_C1_MASTER_SELECT];
        fen       = s_q.ctrl2[`SPCFG_C2_FEN];
        select_output_enable      = s_q.ctrl1[`SPCFG_C1_SELECT_OUTPUT_ENABLE];
        spc       = s_q.ctrl2[`SPCFG_C2_SPC];
        boe       = s_q.ctrl2[`SPCFG_C2_BOE];
        wr        = AVS_WRITE & ~s_q.ack & AVS_BYTEENABLE[0];
        rd        = AVS_READ & ~s_q.ack;
        wbyte     = AVS_WRITEDATA[7:0];
        match_clr = 1'b0;
        fault_clr = 1'b0;
        fault_ev  = 1'b0;
        s_d       = s_q;
        s_d.abort = 1'b0;
        // one wait state: answer on the cycle after the request is seen
        s_d.ack   = (AVS_READ | AVS_WRITE) & ~s_q.ack;
        if (rd) begin
            case (AVS_ADDRESS)
                `SPCFG_OFF_CTRL1:  s_d.rdata = {24'h000000, s_q.ctrl1};
                `SPCFG_OFF_CTRL2:  s_d.rdata = {24'h000000, s_q.ctrl2};
                `SPCFG_OFF_BAUD:   s_d.rdata = {24'h000000, s_q.baud};
                `SPCFG_OFF_STATUS: begin
                    s_d.rdata = {24'h000000, 1'b0, s_q.match_flag, 1'b0, s_q.fault_flag,
                                 3'h0, ~bif.run};
                    s_d.rd_seen_match = s_q.match_flag;
                    s_d.rd_seen_fault = s_q.fault_flag;
                end
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (wr) begin
            case (AVS_ADDRESS)
                `SPCFG_OFF_CTRL1: begin
                    s_d.ctrl1 = wbyte;
                    fault_clr = s_q.rd_seen_fault;
                end
                `SPCFG_OFF_CTRL2: begin
                    s_d.ctrl2 = wbyte & `SPCFG_C2_MASK;
                    if (master && (wbyte[`SPCFG_C2_WIDTH] != s_q.ctrl2[`SPCFG_C2_WIDTH])) begin
                        s_d.abort = 1'b1;
                    end
                end
                `SPCFG_OFF_BAUD:   s_d.baud = wbyte & 8'h77;
                `SPCFG_OFF_STATUS: match_clr = s_q.rd_seen_match & wbyte[`SPCFG_ST_MATCH];
                default: ;
            endcase
        end
        // pin function of the select pin
        if (!master) begin
            s_d.ss_fn = SPCFG_SS_SLAVE_IN;
        end else if (!fen) begin
            s_d.ss_fn = SPCFG_SS_GPIO;
        end else if (!select_output_enable) begin
            s_d.ss_fn = SPCFG_SS_FAULT_IN;
        end else begin
            s_d.ss_fn = SPCFG_SS_AUTO_OUT;
        end
        fault_ev = s_q.active & (s_q.ss_fn == SPCFG_SS_FAULT_IN) & ~ss_s;
        // sticky flags: set beats clear; disable or abort clears all
        if (!s_q.active || s_q.abort) begin
            s_d.match_flag = 1'b0;
            s_d.fault_flag = 1'b0;
        end else begin
            s_d.match_flag = RX_MATCH_EVENT | (s_q.match_flag & ~match_clr);
            s_d.fault_flag = fault_ev | (s_q.fault_flag & ~fault_clr);
        end
        if (match_clr) begin
            s_d.rd_seen_match = 1'b0;
        end
        if (fault_clr) begin
            s_d.rd_seen_fault = 1'b0;
        end
        s_d.irq     = s_q.ctrl2[`SPCFG_C2_MIE] & s_q.match_flag;
        s_d.active  = s_q.ctrl1[`SPCFG_C1_UEN];
        s_d.clk_run = ~(WAIT_MODE & s_q.ctrl2[`SPCFG_C2_WSTOP]);
        // defaults: every pin released to the port
        s_d.sck_o     = 1'b0;
        s_d.sck_oe_n  = 1'b1;
        s_d.mosi_o    = 1'b0;
        s_d.mosi_oe_n = 1'b1;
        s_d.mosi_gpio = 1'b1;
        s_d.miso_o    = 1'b0;
        s_d.miso_oe_n = 1'b1;
        s_d.miso_gpio = 1'b1;
        s_d.ss_o      = 1'b1;
        s_d.ss_oe_n   = 1'b1;
        s_d.ss_gpio   = 1'b1;
        s_d.selected  = 1'b0;
        s_d.rx        = s_q.rx;
        if (s_q.active) begin
            s_d.mosi_gpio = 1'b0;
            s_d.miso_gpio = 1'b0;
            s_d.ss_gpio   = (s_q.ss_fn == SPCFG_SS_GPIO);
            if (master) begin
                s_d.sck_o    = bif.sck;
                s_d.sck_oe_n = 1'b0;
                if (!spc) begin
                    s_d.mosi_o    = MOSI_TX;
                    s_d.mosi_oe_n = 1'b0;
                    s_d.rx        = miso_s;
                end else begin
                    s_d.miso_gpio = 1'b1;
                    s_d.mosi_o    = MOSI_TX;
                    s_d.mosi_oe_n = ~boe;
                    s_d.rx        = mosi_s;
                end
                if (s_q.ss_fn == SPCFG_SS_AUTO_OUT) begin
                    s_d.ss_o    = ~SS_ASSERT;
                    s_d.ss_oe_n = 1'b0;
                end
            end else begin
                s_d.selected = ~ss_s;
                if (!spc) begin
                    s_d.miso_o    = MISO_TX;
                    s_d.miso_oe_n = ~s_d.selected;
                    s_d.rx        = mosi_s;
                end else begin
                    s_d.mosi_gpio = 1'b1;
                    s_d.miso_o    = MISO_TX;
                    s_d.miso_oe_n = ~(boe & s_d.selected);
                    s_d.rx        = miso_s;
                end
            end
        end
    end

    // state register
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.ctrl1    <= `SPCFG_C1_RST;
            s_q.ctrl2    <= `SPCFG_C2_RST;
            s_q.baud     <= `SPCFG_BR_RST;
            s_q.clk_run  <= 1'b1;
            s_q.ss_fn    <= SPCFG_SS_SLAVE_IN;
            s_q.sck_oe_n <= 1'b1;
            s_q.mosi_oe_n <= 1'b1;
            s_q.miso_oe_n <= 1'b1;
            s_q.ss_oe_n  <= 1'b1;
            s_q.ss_o     <= 1'b1;
            s_q.mosi_gpio <= 1'b1;
            s_q.miso_gpio <= 1'b1;
            s_q.ss_gpio  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign AVS_READDATA    = s_q.rdata;
    assign AVS_WAITREQUEST = ~s_q.ack;
    assign IRQ             = s_q.irq;
    assign WIDTH_16        = s_q.ctrl2[`SPCFG_C2_WIDTH];
    assign ABORT           = s_q.abort;
    assign UNIT_CLK_RUN    = s_q.clk_run;
    assign SPI_ACTIVE      = s_q.active;
    assign SCK_O           = s_q.sck_o;
    assign SCK_OE_N        = s_q.sck_oe_n;
    assign MOSI_O          = s_q.mosi_o;
    assign MOSI_OE_N       = s_q.mosi_oe_n;
    assign MOSI_GPIO       = s_q.mosi_gpio;
    assign MISO_O          = s_q.miso_o;
    assign MISO_OE_N       = s_q.miso_oe_n;
    assign MISO_GPIO       = s_q.miso_gpio;
    assign RX_DATA         = s_q.rx;
    assign SS_O            = s_q.ss_o;
    assign SS_OE_N         = s_q.ss_oe_n;
    assign SS_GPIO         = s_q.ss_gpio;
    assign SLAVE_SELECTED  = s_q.selected;
endmodule : spcfg_top
`default_nettype wire

// *** spcfg_asserts.sv ***
// port-level checks for the serial config block
`timescale 1ns/1ns
`default_nettype none
module spcfg_asserts (
    input wire logic        CORE_CLK, // bus clock
    input wire logic        RST_N, // sync reset, low
    input wire logic        AVS_READ, // read strobe
    input wire logic        AVS_WRITE, // write strobe
    input wire logic [31:0] AVS_READDATA, // read data
    input wire logic        AVS_WAITREQUEST, // stall
    input wire logic        IRQ, // interrupt
    input wire logic        WAIT_MODE, // processor waits
    input wire logic        RX_MATCH_EVENT, // match event
    input wire logic        WIDTH_16, // width
    input wire logic        ABORT, // abort pulse
    input wire logic        UNIT_CLK_RUN, // clocks run
    input wire logic        SPI_ACTIVE, // pins owned
    input wire logic        SCK_OE_N, // clock drive
    input wire logic        MOSI_OE_N, // master-out drive
    input wire logic        SS_I, // select in
    input wire logic        SS_OE_N, // select drive
    input wire logic        SS_GPIO, // select as port
    input wire logic        SLAVE_SELECTED // selected
);
    logic       ev_seen_q; // a match event came since reset
    logic [3:0] hi_cnt_q;  // cycles the select pin stayed high, saturating
    // helper state so outputs can be tied to their causes
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ev_seen_q <= 1'b0;
            hi_cnt_q  <= 4'h0;
        end else begin
            ev_seen_q <= ev_seen_q | RX_MATCH_EVENT;
            hi_cnt_q  <= SS_I ? hi_cnt_q + {3'h0, hi_cnt_q != 4'hf} : 4'h0;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    AST_IRQ_CAUSE: assert property (IRQ |-> ev_seen_q) else $error("irq uncaused");
    AST_WAIT_RUN: assert property (!WAIT_MODE |=> UNIT_CLK_RUN) else $error("clocks stopped");
    AST_PINS_OFF: assert property (!SPI_ACTIVE && !$past(SPI_ACTIVE) |-> SS_OE_N && SCK_OE_N && MOSI_OE_N)
        else $error("pin driven off");
    AST_SS_EXCL: assert property (!SS_OE_N |-> !SS_GPIO) else $error("select clash");
    AST_WR_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
    AST_ANSWER: assert property ($rose(AVS_READ || AVS_WRITE) |-> ##[1:2] !AVS_WAITREQUEST)
        else $error("no answer");
    AST_UPPER_ZERO: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
        else $error("upper bits set");
    AST_ABORT_PULSE: assert property (ABORT |=> !ABORT) else $error("long abort");
    AST_ABORT_CHG: assert property ($changed(WIDTH_16) && !SCK_OE_N |-> ($past(ABORT) || ABORT) or ##1 ABORT)
        else $error("no abort");
    AST_SEL_CAUSE: assert property (SLAVE_SELECTED |-> hi_cnt_q < 4'h8) else $error("selected idle");
endmodule : spcfg_asserts
`default_nettype wire

// *** spcfg_far_dev.sv ***
// far-side device: byte-shifting slave or outside master
`timescale 1ns/1ns
`default_nettype none
module spcfg_far_dev (
    input  wire logic       sck,        // clock on the line
    input  wire logic       sel_n,      // select line, low picks this device
    input  wire logic       act_master, // act as outside master
    input  wire logic [7:0] tx_byte,    // byte shifted out
    output var  logic       ss_drv_n,   // select toward the block, 1 = released
    output var  logic       dout,       // data toward the block
    output var  logic       dout_en     // 1 while driving data
);
    logic [7:0] sh_q; // outgoing shifter
    // an outside master selects the block by pulling select low
    assign ss_drv_n = !act_master;
    // drive only while selected, else the bench pull-up wins
    assign dout_en = !sel_n && !act_master;
    assign dout    = sh_q[7];
    // load at selection, shift on falling clock
    always @(negedge sel_n) sh_q = tx_byte;
    always @(negedge sck) if (!sel_n) sh_q = {sh_q[6:0], 1'b0};
endmodule : spcfg_far_dev
`default_nettype wire

// *** spcfg_top_tb_top.sv ***
// self-checking bench for the serial config block
`timescale 1ns/1ns
`default_nettype none
`include "spcfg_defines.svh"
module spcfg_top_tb_top;
    logic        clk, rst_n, rd, wr, wait_mode, match_ev, ss_assert, act_master, abort_seen;
    logic [3:0]  addr, be;
    logic [31:0] wdata;
    logic [7:0]  rv;
    int          n_errors, n_tests, cyc, n, i;
    wire [31:0]  rdata;
    wire         waitreq, irq, w16, abort, clk_run, spi_act, sck_o, sck_oe_n, mosi_o, mosi_oe_n, mosi_gpio;
    wire         miso_o, miso_oe_n, miso_gpio, ss_o, ss_oe_n, ss_gpio, slv_sel, far_ss_n, far_dout, far_en;
    wire         sck_i, mosi_i, miso_i, ss_i;
    // pin levels: released lines go to their pulls
    assign sck_i  = sck_oe_n ? 1'b0 : sck_o;
    assign ss_i   = ss_oe_n ? far_ss_n : ss_o;
    assign mosi_i = mosi_oe_n ? 1'b1 : mosi_o;
    assign miso_i = !miso_oe_n ? miso_o : (far_en ? far_dout : 1'b1);
    spcfg_top u_dut (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .IRQ(irq),
        .WAIT_MODE(wait_mode), .RX_MATCH_EVENT(match_ev), .WIDTH_16(w16), .ABORT(abort), .UNIT_CLK_RUN(clk_run),
        .SPI_ACTIVE(spi_act), .SCK_I(sck_i), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .MOSI_I(mosi_i),
        .MOSI_TX(far_dout), .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n), .MOSI_GPIO(mosi_gpio), .MISO_I(miso_i),
        .MISO_TX(sck_o), .MISO_O(miso_o), .MISO_OE_N(miso_oe_n), .MISO_GPIO(miso_gpio), .RX_DATA(),
        .SS_I(ss_i), .SS_ASSERT(ss_assert), .SS_O(ss_o), .SS_OE_N(ss_oe_n), .SS_GPIO(ss_gpio),
        .SLAVE_SELECTED(slv_sel));
    spcfg_far_dev u_far (.sck(sck_i), .sel_n(ss_i), .act_master(act_master), .tx_byte(8'ha5),
        .ss_drv_n(far_ss_n), .dout(far_dout), .dout_en(far_en));
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict;
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= {24'h0, d};
        wr    <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        do @(posedge clk); while (waitreq !== 1'b0);
        d = rdata[7:0];
        rd <= 1'b0;
    endtask : bus_rd
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle
    task automatic pulse_match;
        @(posedge clk);
        match_ev <= 1'b1;
        @(posedge clk);
        match_ev <= 1'b0;
    endtask : pulse_match
    // cycles between two rising sck edges
    task automatic sck_period(output int p);
        time t;
        @(posedge sck_o);
        t = $time;
        @(posedge sck_o);
        p = int'(($time - t) / 20);
    endtask : sck_period
    // hang guard and abort pulse monitor
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (abort === 1'b1) abort_seen <= 1'b1;
        if (cyc == 60000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        {rst_n, rd, wr, wait_mode, match_ev, ss_assert, act_master, abort_seen} = 8'h00;
        addr = 4'h0;
        be = 4'hf;
        wdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        chk("irq reset", irq, 1'b0);
        chk("clk run reset", clk_run, 1'b1);
        bus_rd(`SPCFG_OFF_BAUD, rv);
        chk("baud reset", rv, `SPCFG_BR_RST);
        bus_wr(4'h2, 8'hff);
        bus_rd(4'h2, rv);
        chk("unmapped", rv, 8'h00);
        bus_wr(`SPCFG_OFF_BAUD, 8'h73);
        be <= 4'he;
        bus_wr(`SPCFG_OFF_BAUD, 8'h11);
        be <= 4'hf;
        bus_rd(`SPCFG_OFF_BAUD, rv);
        chk("baud rw", rv, 8'h73);
        // select pin function
        for (i = 0; i < 8; i++) begin
            bus_wr(`SPCFG_OFF_CTRL2, {3'b0, i[1], 4'b0});
            bus_wr(`SPCFG_OFF_CTRL1, {3'b010, i[2], 2'b0, i[0], 1'b0});
            settle;
            chk("select port", ss_gpio, i[2] & !i[1]);
            chk("select drive", ss_oe_n, !(i[2] & i[1] & i[0]));
        end
        act_master <= 1'b0;
        bus_wr(`SPCFG_OFF_CTRL1, 8'h42);
        act_master <= 1'b1;
        settle;
        chk("selected", slv_sel, 1'b1);
        act_master <= 1'b0;
        settle;
        chk("released", slv_sel, 1'b0);
        // data pin use
        for (i = 0; i < 8; i++) begin
            act_master <= !i[2];
            bus_wr(`SPCFG_OFF_CTRL2, {4'b0, i[0], 2'b0, i[1]});
            bus_wr(`SPCFG_OFF_CTRL1, {3'b010, i[2], 4'b0});
            settle;
            chk("mosi drive", mosi_oe_n, !(i[2] & (!i[1] | i[0])));
            chk("miso drive", miso_oe_n, !(!i[2] & (!i[1] | i[0])));
            chk("mosi port", mosi_gpio, !i[2] & i[1]);
            chk("miso port", miso_gpio, i[2] & i[1]);
        end
        act_master <= 1'b0;
        bus_wr(`SPCFG_OFF_CTRL2, 8'h02);
        wait_mode <= 1'b1;
        settle;
        chk("wait stop", clk_run, 1'b0);
        bus_wr(`SPCFG_OFF_CTRL2, 8'h00);
        settle;
        chk("wait run", clk_run, 1'b1);
        wait_mode <= 1'b0;
        pulse_match;
        settle;
        chk("irq masked", irq, 1'b0);
        bus_wr(`SPCFG_OFF_CTRL2, 8'h80);
        settle;
        chk("irq raised", irq, 1'b1);
        bus_rd(`SPCFG_OFF_STATUS, rv);
        chk("match flag", rv & 8'h40, 8'h40);
        bus_wr(`SPCFG_OFF_STATUS, 8'h40);
        settle;
        chk("irq cleared", irq, 1'b0);
        // master width change
        bus_wr(`SPCFG_OFF_CTRL1, 8'h50);
        pulse_match;
        abort_seen <= 1'b0;
        bus_wr(`SPCFG_OFF_CTRL2, 8'hc0);
        settle;
        chk("width 16", w16, 1'b1);
        chk("abort seen", abort_seen, 1'b1);
        bus_rd(`SPCFG_OFF_STATUS, rv);
        chk("flags", rv & 8'h50, 8'h00);
        bus_wr(`SPCFG_OFF_CTRL2, 8'h00);
        settle;
        chk("width 8", w16, 1'b0);
        // serial clock period
        ss_assert <= 1'b1;
        foreach (rv[j]) if (j < 4) begin
            bus_wr(`SPCFG_OFF_BAUD, (j == 0) ? 8'h00 : (j == 1) ? 8'h12 : (j == 2) ? 8'h40 : 8'h77);
            repeat (2) sck_period(n);
            chk("sck period", n, (j == 0) ? 2 : (j == 1) ? 16 : (j == 2) ? 10 : 2048);
        end
        ss_assert <= 1'b0;
        bus_wr(`SPCFG_OFF_CTRL1, 8'h00);
        settle;
        chk("unit off", spi_act, 1'b0);
        chk("ports", {ss_gpio, mosi_gpio, miso_gpio, sck_oe_n}, 4'hf);
        give_verdict;
    end
endmodule : spcfg_top_tb_top
bind spcfg_top spcfg_asserts u_chk (.*);
`default_nettype wire
